// [pkg/cscl_pkg.sv]
package cscl_pkg;

  // ==========================================================
  // Oscillator indices
  localparam int unsigned OSC_FAST_RC   = 0;
  localparam int unsigned OSC_FAST_XTAL = 1;
  localparam int unsigned OSC_SLOW_RC   = 2;
  localparam int unsigned OSC_SLOW_XTAL = 3;
  localparam int unsigned OSC_NUM       = 4;

  // ==========================================================
  // Field encodings
  localparam logic [2:0] SEL_DIV1   = 3'h0;
  localparam logic [2:0] SEL_DIV2   = 3'h1;
  localparam logic [2:0] SEL_DIV64  = 3'h6;
  localparam logic [2:0] SEL_SUB    = 3'h7;
  localparam logic       HSRC_RC    = 1'h0;
  localparam logic       HSRC_XTAL  = 1'h1;
  localparam logic       LSRC_RC    = 1'h0;
  localparam logic       LSRC_XTAL  = 1'h1;
  localparam logic [1:0] RCF_8MHZ   = 2'h0;
  localparam logic [1:0] RCF_12MHZ  = 2'h1;
  localparam logic [1:0] RCF_16MHZ  = 2'h2;
  localparam logic [1:0] RCF_8MHZ_B = 2'h3;
  localparam logic [4:0] MHZ_8      = 5'h08;
  localparam logic [4:0] MHZ_12     = 5'h0C;
  localparam logic [4:0] MHZ_16     = 5'h10;

  // ==========================================================
  // Reset values
  localparam logic [2:0] RST_SYSCLK_SELECT = 3'h0;
  localparam logic       RST_HIGH_SOURCE   = 1'h0;
  localparam logic       RST_LOW_SOURCE    = 1'h0;

  // ==========================================================
  // Start-up counts, in oscillator ticks
  localparam int unsigned FAST_STARTUP_TICKS = 16;
  localparam int unsigned SLOW_STARTUP_TICKS = 1024;
  localparam int unsigned STARTUP_CNT_W      = 16;
  localparam int unsigned DIV_CNT_W          = 6;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    CSCL_RUN    = 2'b01,
    CSCL_SWITCH = 2'b10
  } cscl_state_t;

  typedef struct packed {
    logic [2:0] sysclk_select;
    logic       high_source_select;
    logic       low_source_select;
    logic [1:0] rc_freq_select;
    logic       fast_rc_enable;
    logic       fast_crystal_enable;
    logic       slow_crystal_enable;
    logic       high_idle_enable;
    logic       low_idle_enable;
    logic       slow_pins_osc;
  } cscl_ctrl_t;

endpackage : cscl_pkg

// [logic/cscl_sync_edge.sv]
`timescale 1ns/100ps
module cscl_sync_edge #(
  parameter int unsigned N = 4
) (
  // Clock, reset and enable
  input  wire logic         core_clk_i,
  input  wire logic         rstn_i,
  input  wire logic         ce_i,
  // Raw levels and rising-edge pulses
  input  wire logic [N-1:0] raw_i,
  output logic      [N-1:0] rise_o
);

  logic [N-1:0] meta_ff;
  logic [N-1:0] sync_ff;
  logic [N-1:0] last_ff;

  if (N < 1) begin : g_chk
    $error("cscl_sync_edge: N must be at least 1");
  end

  // ==========================================================
  // Two-stage synchroniser, then edge detect on the second stage
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
      last_ff <= '0;
    end else if (ce_i) begin
      meta_ff <= raw_i;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign rise_o = sync_ff & ~last_ff & {N{ce_i}};

endmodule : cscl_sync_edge

// [logic/cscl_system_clock_select.sv]
`timescale 1ns/100ps
module cscl_system_clock_select #(
  parameter int unsigned FAST_STARTUP = cscl_pkg::FAST_STARTUP_TICKS,
  parameter int unsigned SLOW_STARTUP = cscl_pkg::SLOW_STARTUP_TICKS
) (
  // Clock, reset, enable
  input  wire logic                 core_clk_i,
  input  wire logic                 rstn_i,
  input  wire logic                 ce_i,
  // Control bits and CPU state
  input  wire cscl_pkg::cscl_ctrl_t ctrl_i,
  input  wire logic [1:0]           rc_freq_option_i,
  input  wire logic                 halt_i,
  // Oscillator raw outputs, asynchronous
  input  wire logic [3:0]           osc_raw_i,
  // Oscillator enables and status
  output logic      [3:0]           osc_en_o,
  output logic      [3:0]           osc_ready_o,
  output logic                      slow_pins_osc_o,
  output logic      [4:0]           rc_option_mhz_o,
  output logic      [4:0]           rc_trim_mhz_o,
  output logic                      rc_freq_mismatch_o,
  output logic                      switching_o,
  // Clock ticks
  output logic                      sys_tick_o,
  output logic                      sub_tick_o,
  output logic      [6:0]           high_div_tick_o
);

  localparam int unsigned CW = cscl_pkg::STARTUP_CNT_W;

  if (FAST_STARTUP < 1 || FAST_STARTUP >= (1 << CW) ||
      SLOW_STARTUP < 1 || SLOW_STARTUP >= (1 << CW)) begin : g_chk
    $error("cscl_system_clock_select: start-up count out of range");
  end

  function automatic logic [4:0] rc_mhz(input logic [1:0] code);
    logic [4:0] mhz;
    mhz = cscl_pkg::MHZ_8;
    if (code == cscl_pkg::RCF_12MHZ) mhz = cscl_pkg::MHZ_12;
    else if (code == cscl_pkg::RCF_16MHZ) mhz = cscl_pkg::MHZ_16;
    return mhz;
  endfunction : rc_mhz

  // ==========================================================
  // Committed selection and switch state
  cscl_pkg::cscl_state_t state_ff;
  cscl_pkg::cscl_state_t nxt_state;
  logic [2:0]            sel_ff;
  logic                  hsrc_ff;
  logic                  lsrc_ff;
  logic [cscl_pkg::DIV_CNT_W-1:0] div_cnt_ff;
  logic [CW-1:0]         cnt_ff [4];
  logic [3:0]            osc_tick;
  logic [3:0]            osc_ready;
  logic [3:0]            osc_en;
  logic [6:0]            div_tick;
  logic [4:0]            rc_option_mhz_ff;
  logic [4:0]            rc_trim_mhz_ff;

  cscl_sync_edge #(
    .N (4)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .ce_i       (ce_i),
    .raw_i      (osc_raw_i),
    .rise_o     (osc_tick)
  );

  // ==========================================================
  // Request decode
  wire       req_high   = ctrl_i.sysclk_select != cscl_pkg::SEL_SUB;
  wire       cur_high   = sel_ff != cscl_pkg::SEL_SUB;
  wire [1:0] req_h_idx  = ctrl_i.high_source_select ? 2'(cscl_pkg::OSC_FAST_XTAL)
                                                    : 2'(cscl_pkg::OSC_FAST_RC);
  wire [1:0] req_l_idx  = ctrl_i.low_source_select ? 2'(cscl_pkg::OSC_SLOW_XTAL)
                                                   : 2'(cscl_pkg::OSC_SLOW_RC);
  wire [1:0] cur_h_idx  = hsrc_ff ? 2'(cscl_pkg::OSC_FAST_XTAL)
                                  : 2'(cscl_pkg::OSC_FAST_RC);
  wire [1:0] cur_l_idx  = lsrc_ff ? 2'(cscl_pkg::OSC_SLOW_XTAL)
                                  : 2'(cscl_pkg::OSC_SLOW_RC);
  wire       req_differs = (ctrl_i.sysclk_select != sel_ff) ||
                           (ctrl_i.high_source_select != hsrc_ff) ||
                           (ctrl_i.low_source_select != lsrc_ff);
  wire       switching  = state_ff == cscl_pkg::CSCL_SWITCH;

  // ==========================================================
  // Oscillator enables
  wire awake_h  = !halt_i || ctrl_i.high_idle_enable;
  wire awake_l  = !halt_i || ctrl_i.low_idle_enable;
  wire need_hxt = (cur_high && hsrc_ff == cscl_pkg::HSRC_XTAL) ||
                  (switching && req_high && ctrl_i.high_source_select);
  wire need_hrc = (cur_high && hsrc_ff == cscl_pkg::HSRC_RC) ||
                  (switching && req_high && !ctrl_i.high_source_select);

  assign osc_en[cscl_pkg::OSC_FAST_XTAL] = awake_h &&
                                           (need_hxt || ctrl_i.fast_crystal_enable);
  assign osc_en[cscl_pkg::OSC_FAST_RC]   = awake_h &&
                                           (need_hrc || ctrl_i.fast_rc_enable);
  assign osc_en[cscl_pkg::OSC_SLOW_RC]   = awake_l;
  assign osc_en[cscl_pkg::OSC_SLOW_XTAL] = awake_l && ctrl_i.slow_crystal_enable &&
                                           ctrl_i.slow_pins_osc;

  // ==========================================================
  // Start-up counters: a source is usable once it has ticked long enough
  for (genvar i = 0; i < 4; i++) begin : g_start
    localparam logic [CW-1:0] LIMIT = (i == cscl_pkg::OSC_SLOW_XTAL) ?
                                      CW'(SLOW_STARTUP) : CW'(FAST_STARTUP);
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        cnt_ff[i] <= '0;
      end else if (ce_i) begin
        if (!osc_en[i]) cnt_ff[i] <= '0;
        else if (osc_tick[i] && cnt_ff[i] != LIMIT) cnt_ff[i] <= cnt_ff[i] + CW'(1);
      end
    end
    assign osc_ready[i] = osc_en[i] && (cnt_ff[i] == LIMIT);
  end

  // ==========================================================
  // High-speed and sub clock paths
  wire high_tick = osc_tick[cur_h_idx] && osc_ready[cur_h_idx];
  wire sub_tick  = osc_tick[cur_l_idx] && osc_ready[cur_l_idx];

  assign div_tick[0] = high_tick;
  for (genvar k = 1; k < 7; k++) begin : g_div
    assign div_tick[k] = high_tick && (&div_cnt_ff[k-1:0]);
  end

  wire sys_raw   = cur_high ? div_tick[sel_ff] : sub_tick;
  wire req_ready = (!req_high || osc_ready[req_h_idx]) &&
                   (osc_ready[req_l_idx] ||
                    (req_high && ctrl_i.low_source_select == lsrc_ff));
  wire commit    = switching && req_differs && req_ready && !sys_raw && !halt_i;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      cscl_pkg::CSCL_RUN: begin
        if (req_differs) nxt_state = cscl_pkg::CSCL_SWITCH;
      end
      cscl_pkg::CSCL_SWITCH: begin
        if (commit || !req_differs) nxt_state = cscl_pkg::CSCL_RUN;
      end
      default: nxt_state = cscl_pkg::CSCL_RUN;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff   <= cscl_pkg::CSCL_RUN;
      sel_ff     <= cscl_pkg::RST_SYSCLK_SELECT;
      hsrc_ff    <= cscl_pkg::RST_HIGH_SOURCE;
      lsrc_ff    <= cscl_pkg::RST_LOW_SOURCE;
      div_cnt_ff <= '0;
    end else if (ce_i) begin
      state_ff <= nxt_state;
      if (commit) begin
        sel_ff  <= ctrl_i.sysclk_select;
        hsrc_ff <= ctrl_i.high_source_select;
        lsrc_ff <= ctrl_i.low_source_select;
      end
      if (high_tick) div_cnt_ff <= div_cnt_ff + cscl_pkg::DIV_CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sys_tick_o       <= 1'b0;
      sub_tick_o       <= 1'b0;
      high_div_tick_o  <= '0;
      rc_option_mhz_ff <= cscl_pkg::MHZ_8;
      rc_trim_mhz_ff   <= cscl_pkg::MHZ_8;
    end else if (ce_i) begin
      sys_tick_o       <= sys_raw && !halt_i;
      sub_tick_o       <= sub_tick;
      high_div_tick_o  <= div_tick;
      rc_option_mhz_ff <= rc_mhz(rc_freq_option_i);
      rc_trim_mhz_ff   <= rc_mhz(ctrl_i.rc_freq_select);
    end
  end

  assign osc_en_o           = osc_en;
  assign osc_ready_o        = osc_ready;
  assign slow_pins_osc_o    = ctrl_i.slow_pins_osc;
  assign rc_option_mhz_o    = rc_option_mhz_ff;
  assign rc_trim_mhz_o      = rc_trim_mhz_ff;
  assign rc_freq_mismatch_o = rc_option_mhz_ff != rc_trim_mhz_ff;
  assign switching_o        = switching;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  a_sub_path_sel: assert property (
    (ce_i && !cur_high && sub_tick && !halt_i) |=> sys_tick_o)
    else $error("sub clock tick not passed to system clock");

  a_div2_ratio: assert property (
    (sel_ff == cscl_pkg::SEL_DIV2 && sys_raw) |-> div_cnt_ff[0])
    else $error("divide by two tick on wrong divider phase");

  a_div64_ratio: assert property (
    (sel_ff == cscl_pkg::SEL_DIV64 && sys_raw) |-> (&div_cnt_ff))
    else $error("divide by 64 tick on wrong divider phase");

  a_halt_gates: assert property (
    (ce_i && halt_i) |=> !sys_tick_o)
    else $error("system clock ticked while halted");

  a_sel_hold: assert property (
    (!commit) |=> $stable(sel_ff) && $stable(hsrc_ff) && $stable(lsrc_ff))
    else $error("selection changed without a commit");

  a_commit_safe: assert property (
    commit |-> !sys_raw && ((ctrl_i.sysclk_select == cscl_pkg::SEL_SUB) ?
                             osc_ready[req_l_idx] : osc_ready[req_h_idx]))
    else $error("selection committed during a tick or before ready");

  a_xtal_start: assert property (
    osc_ready[cscl_pkg::OSC_SLOW_XTAL] |->
      ctrl_i.slow_crystal_enable && cnt_ff[cscl_pkg::OSC_SLOW_XTAL] == CW'(SLOW_STARTUP))
    else $error("slow crystal ready without enable or start-up delay");

  a_hsrc_path: assert property (
    (high_tick && hsrc_ff == cscl_pkg::HSRC_XTAL) |-> osc_tick[cscl_pkg::OSC_FAST_XTAL])
    else $error("high clock not taken from fast crystal");

  a_lsrc_path: assert property (
    (sub_tick && lsrc_ff == cscl_pkg::LSRC_RC) |-> osc_tick[cscl_pkg::OSC_SLOW_RC])
    else $error("sub clock not taken from slow RC");

  a_fast_stop: assert property (
    (!cur_high && !switching && !ctrl_i.fast_crystal_enable) |->
      !osc_en[cscl_pkg::OSC_FAST_XTAL])
    else $error("fast crystal kept running without its enable");

  a_rc_decode: assert property (
    (ce_i && ctrl_i.rc_freq_select == cscl_pkg::RCF_8MHZ_B) |=>
      rc_trim_mhz_o == cscl_pkg::MHZ_8)
    else $error("rc_freq_select 11 not decoded as 8 MHz");

endmodule : cscl_system_clock_select

// [verif/cscl_system_clock_select_tb_top.sv]
`timescale 1ns/100ps
module cscl_system_clock_select_tb_top;
  // ==========================================================
  // Signals
  logic                 core_clk_i;
  logic                 rstn_i;
  logic                 halt_i;
  logic                 ce;
  logic [1:0]           opt;
  logic [1:0]           r;
  logic [3:0]           raw;
  cscl_pkg::cscl_ctrl_t ctrl;
  logic [3:0]           osc_en;
  logic [3:0]           osc_rdy;
  logic                 pins;
  logic [4:0]           opt_mhz;
  logic [4:0]           trim_mhz;
  logic                 mism;
  logic                 sw;
  logic                 sys_t;
  logic                 sub_t;
  logic [6:0]           div_t;
  logic [31:0]          n_sys;
  logic [31:0]          n_sub;
  logic [31:0]          d_sys;
  logic [31:0]          d_sub;
  logic [31:0]          n_div [7];
  logic [31:0]          d_div [7];
  int                   fails;
  int                   checked;

  // ==========================================================
  // Design, start-up counts shortened
  cscl_system_clock_select #(.FAST_STARTUP(2), .SLOW_STARTUP(4)) i_dut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(ce), .ctrl_i(ctrl),
    .rc_freq_option_i(opt), .halt_i(halt_i), .osc_raw_i(raw), .osc_en_o(osc_en),
    .osc_ready_o(osc_rdy), .slow_pins_osc_o(pins), .rc_option_mhz_o(opt_mhz),
    .rc_trim_mhz_o(trim_mhz), .rc_freq_mismatch_o(mism), .switching_o(sw),
    .sys_tick_o(sys_t), .sub_tick_o(sub_t), .high_div_tick_o(div_t)
  );

  // ==========================================================
  // Tick counters
  always @(posedge core_clk_i) begin
    n_sys <= n_sys + 32'(sys_t);
    n_sub <= n_sub + 32'(sub_t);
    for (int k = 0; k < 7; k++) begin
      n_div[k] <= n_div[k] + 32'(div_t[k]);
    end
  end

  // ==========================================================
  // Model and tasks
  function automatic logic [4:0] mhz(input logic [1:0] c);
    return (c == 2'h1) ? 5'h0C : (c == 2'h2) ? 5'h10 : 5'h08;
  endfunction : mhz

  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : cyc

  // Oscillator ticks on mask bits, then idle so every pulse has landed
  task automatic pulse(input logic [3:0] m, input int n);
    logic [31:0] s0;
    logic [31:0] u0;
    logic [31:0] v0 [7];
    s0 = n_sys;
    u0 = n_sub;
    v0 = n_div;
    repeat (n) begin
      raw <= m;
      cyc(2);
      raw <= 4'h0;
      cyc(2);
    end
    cyc(8);
    d_sys = n_sys - s0;
    d_sub = n_sub - u0;
    for (int k = 0; k < 7; k++) begin
      d_div[k] = n_div[k] - v0[k];
    end
  endtask : pulse

  task automatic sel(input logic [2:0] s, input logic h, input logic l);
    ctrl.sysclk_select <= s;
    ctrl.high_source_select <= h;
    ctrl.low_source_select <= l;
    cyc(2);
    for (int i = 0; i < 20 && sw !== 1'b0; i++) begin
      cyc(1);
    end
    if (sw !== 1'b0) begin
      fails++;
      give_verdict();
    end
  endtask : sel

  // ==========================================================
  // Clock and main sequence
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  initial begin
    fails = 0;
    checked = 0;
    n_sys = 32'h0;
    n_sub = 32'h0;
    for (int k = 0; k < 7; k++) begin
      n_div[k] = 32'h0;
    end
    rstn_i = 1'b0;
    halt_i = 1'b0;
    ce = 1'b1;
    opt = 2'h0;
    raw = 4'h0;
    ctrl = '0;
    ctrl.fast_rc_enable = 1'b1;
    r = 2'($urandom(56));
    cyc(6);
    rstn_i <= 1'b1;
    cyc(2);
    @(negedge core_clk_i);
    check(32'(trim_mhz), 32'h8);
    check(32'(osc_en[3]), 32'h0);
    check(32'(pins), 32'h0);
    cyc(1);
    ctrl.sysclk_select <= 3'h7;
    ctrl.low_source_select <= 1'b1;
    cyc(10);
    check(32'(sw), 32'h1);
    sel(3'h0, 1'b0, 1'b0);
    ctrl.slow_pins_osc <= 1'b1;
    ctrl.slow_crystal_enable <= 1'b1;
    ctrl.fast_crystal_enable <= 1'b1;
    cyc(2);
    @(negedge core_clk_i);
    check(32'(pins), 32'h1);
    check(32'(osc_en[3]), 32'h1);
    cyc(1);
    pulse(4'hF, 3);
    check(32'(osc_rdy), 32'h7);
    pulse(4'h8, 1);
    check(32'(osc_rdy), 32'hF);
    for (int s = 0; s < 7; s++) begin
      sel(3'(s), 1'b0, 1'b0);
      pulse(4'h1, 64);
      check(d_sys, 32'h40 >> s);
      for (int k = 0; k < 7; k++) begin
        check(d_div[k], 32'h40 >> k);
      end
    end
    sel(3'h0, 1'b1, 1'b0);
    pulse(4'h1, 8);
    check(d_sys, 32'h0);
    pulse(4'h2, 8);
    check(d_sys, 32'h8);
    sel(3'h7, 1'b1, 1'b0);
    pulse(4'h4, 8);
    check(d_sys, 32'h8);
    check(d_sub, 32'h8);
    pulse(4'h2, 8);
    check(d_sys, 32'h0);
    check(d_div[0], 32'h8);
    sel(3'h7, 1'b1, 1'b1);
    pulse(4'h4, 8);
    check(d_sub, 32'h0);
    pulse(4'h8, 8);
    check(d_sys, 32'h8);
    // Clock enable low freezes the synchroniser and every tick output
    ce <= 1'b0;
    pulse(4'h8, 4);
    check(d_sys, 32'h0);
    check(d_sub, 32'h0);
    ce <= 1'b1;
    cyc(2);
    ctrl.fast_crystal_enable <= 1'b0;
    ctrl.fast_rc_enable <= 1'b0;
    cyc(2);
    @(negedge core_clk_i);
    check(32'(osc_en[1:0]), 32'h0);
    cyc(1);
    halt_i <= 1'b1;
    ctrl.low_idle_enable <= 1'b1;
    cyc(2);
    pulse(4'h8, 8);
    check(d_sys, 32'h0);
    check(d_sub, 32'h8);
    ctrl.low_idle_enable <= 1'b0;
    ctrl.high_idle_enable <= 1'b1;
    ctrl.fast_crystal_enable <= 1'b1;
    cyc(2);
    @(negedge core_clk_i);
    check(32'(osc_en[3]), 32'h0);
    check(32'(osc_en[1]), 32'h1);
    cyc(1);
    halt_i <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      opt <= 2'(i);
      ctrl.rc_freq_select <= 2'(i >> 2) ^ r;
      cyc(3);
      @(negedge core_clk_i);
      check(32'(opt_mhz), 32'(mhz(opt)));
      check(32'(trim_mhz), 32'(mhz(ctrl.rc_freq_select)));
      check(32'(mism), 32'(mhz(opt) != mhz(ctrl.rc_freq_select)));
      cyc(1);
    end
    // Reset in mid-run: fast RC /1 and slow RC again, pending switch held
    rstn_i <= 1'b0;
    cyc(6);
    rstn_i <= 1'b1;
    cyc(2);
    pulse(4'h5, 4);
    check(d_sys, 32'h2);
    check(d_sub, 32'h2);
    check(32'(sw), 32'h1);
    give_verdict();
  end
endmodule : cscl_system_clock_select_tb_top
